/* File: design/sasr_core.sv */
/*
 * Conversion control and serial readout of a six-channel, three-pair
 * simultaneous-sampling converter: start edge detection, busy timing,
 * range selection, control word, result images and three serial lines.
 * Assumes the analog core presents six results on conv_result, the
 * serial clock is host-made and idles outside frames, and results are
 * not read while a conversion is finishing.
 */
// How it works
// - Hardware mode samples range pin at busy fall
// - Range high gives 2x, low 4x reference
// - After reset, pin range waits for busy fall
// - Software mode uses per-pair range bits
// - Bypass bit clear enables reference buffers
// - Start rising edge begins conversion, raises busy
// - Busy falls three microseconds after start
// - Starts ignored while busy high
// - Conversion end loads output results
// - Each line driven only when enabled
// - Three lines read in 32 clocks
// - Two lines split channels 1,2,5 / 3,4,6
// - Line A alone carries all six, 96 clocks
// - Zeros after all results shifted out
// - Unconverted pairs keep slots, filled zero
// - Serial logic runs on host serial clock
// - Chip select fall shows first MSB
// - Sixteen bits MSB first, leading zeros
// - Software mode: selected pairs, start A only
// - Control word resets to all zeros
`timescale 1ns/1ps

module sasr_core #(
    parameter int RES_BITS = 16
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic pair_a_start,
    input wire logic pair_b_start,
    input wire logic pair_c_start,
    input wire logic range_pin,
    input wire logic sw_select_mode,
    input wire logic serial_parallel_select,
    input wire logic out_a_enable,
    input wire logic out_b_enable,
    input wire logic out_c_enable,
    input wire logic ctrl_write,
    input wire logic [7:0] ctrl_data,
    input wire logic [95:0] conv_result,
    input wire logic sclk,
    input wire logic cs_n,
    output logic busy,
    output logic [2:0] conv_pairs,
    output logic [2:0] pair_range,
    output logic ref_buffer_enable,
    output logic ref_internal_enable,
    output logic dout_a,
    output logic dout_a_oe,
    output logic dout_b,
    output logic dout_b_oe,
    output logic dout_c,
    output logic dout_c_oe
);

    localparam logic [sasr_pkg::WORD_BITS-1:0] RES_MASK =
        sasr_pkg::WORD_BITS'({RES_BITS{1'b1}});

    logic [sasr_pkg::SY_W-1:0] sync1_ff;
    logic [sasr_pkg::SY_W-1:0] sync2_ff;
    logic [2:0] start_prev_ff;
    logic [2:0] start_rise;
    logic sw_mode;
    logic [2:0] out_en;
    sasr_pkg::sasr_state_e state_ff;
    logic busy_ff;
    logic [sasr_pkg::CNT_W-1:0] cnt_ff;
    logic [2:0] conv_pairs_ff;
    logic [sasr_pkg::CTRL_W-1:0] ctrl_ff;
    logic hw_range_ff;
    logic [2:0] pair_range_ff;
    logic ref_buffer_enable_ff;
    logic ref_internal_enable_ff;
    logic [sasr_pkg::IMG_BITS-1:0] img_a_ff;
    logic [sasr_pkg::IMG_BITS-1:0] img_b_ff;
    logic [sasr_pkg::IMG_BITS-1:0] img_c_ff;
    logic [sasr_pkg::IMG_BITS-1:0] nxt_img_a;
    logic [sasr_pkg::IMG_BITS-1:0] nxt_img_b;
    logic [sasr_pkg::IMG_BITS-1:0] nxt_img_c;
    logic epoch_ff;
    logic rst_link_ff;
    logic conv_end;
    logic [sasr_pkg::POS_W-1:0] pos_ff;
    logic seen_ff;
    logic [sasr_pkg::POS_W-1:0] eff_pos;
    logic [sasr_pkg::POS_W-1:0] bit_idx;
    logic serial_on;

    // Result word of one channel: low bits kept, upper bits zero
    function automatic logic [sasr_pkg::WORD_BITS-1:0] ch_word(
        input logic [95:0] res,
        input logic [2:0] pairs,
        input int ch
    );
        logic [sasr_pkg::WORD_BITS-1:0] w;
        w = res[ch*sasr_pkg::WORD_BITS +: sasr_pkg::WORD_BITS] & RES_MASK;
        return pairs[ch/2] ? w : '0;
    endfunction

    // Pin synchroniser, two stages
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            start_prev_ff <= '0;
        end
        else if (ce)
        begin
            sync1_ff <= {out_c_enable, out_b_enable, out_a_enable,
                         serial_parallel_select, sw_select_mode, range_pin,
                         pair_c_start, pair_b_start, pair_a_start};
            sync2_ff <= sync1_ff;
            start_prev_ff <= sync2_ff[sasr_pkg::SY_START +: 3];
        end
    end

    assign start_rise = sync2_ff[sasr_pkg::SY_START +: 3] & ~start_prev_ff;
    assign sw_mode = sync2_ff[sasr_pkg::SY_SW];
    assign out_en = sync2_ff[sasr_pkg::SY_EN +: 3];
    assign conv_end = ce && (state_ff == sasr_pkg::SASR_CONV) &&
                      (cnt_ff == sasr_pkg::CONV_LAST);

    // Control word, written from the parallel side
    always_ff @(posedge clk)
    begin
        if (reset)
            ctrl_ff <= sasr_pkg::CTRL_RESET;
        else if (ce && ctrl_write)
            ctrl_ff <= ctrl_data;
    end

    // Conversion sequencer
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_ff <= sasr_pkg::SASR_IDLE;
            busy_ff <= 1'b0;
            cnt_ff <= '0;
            conv_pairs_ff <= '0;
        end
        else if (ce)
        begin
            case (state_ff)
                sasr_pkg::SASR_IDLE:
                begin
                    // software mode uses select bits, start A only
                    if (sw_mode && start_rise[0])
                    begin
                        state_ff <= sasr_pkg::SASR_CONV;
                        busy_ff <= 1'b1;
                        cnt_ff <= '0;
                        conv_pairs_ff <= ctrl_ff[sasr_pkg::CTRL_SEL_LO +: 3];
                    end
                    else if (!sw_mode && (start_rise != 3'h0))
                    begin
                        state_ff <= sasr_pkg::SASR_CONV;
                        busy_ff <= 1'b1;
                        cnt_ff <= '0;
                        conv_pairs_ff <= start_rise;
                    end
                end
                sasr_pkg::SASR_CONV:
                begin
                    // starts not looked at while busy
                    // busy ends after the conversion time
                    if (cnt_ff == sasr_pkg::CONV_LAST)
                    begin
                        state_ff <= sasr_pkg::SASR_IDLE;
                        busy_ff <= 1'b0;
                    end
                    else
                        cnt_ff <= cnt_ff + 1'b1;
                end
                default:
                begin
                    state_ff <= sasr_pkg::SASR_IDLE;
                    busy_ff <= 1'b0;
                end
            endcase
        end
    end

    // Range selection and reference control
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            hw_range_ff <= 1'b0;
            pair_range_ff <= '0;
            ref_buffer_enable_ff <= 1'b1;
            ref_internal_enable_ff <= 1'b0;
        end
        else if (ce)
        begin
            // held at reset value until then
            if (conv_end)
                hw_range_ff <= sync2_ff[sasr_pkg::SY_RANGE];
            pair_range_ff <= sw_mode ? ctrl_ff[sasr_pkg::CTRL_RNG_LO +: 3]
                                     : {3{hw_range_ff}};
            // bypass bit clear keeps buffers on
            ref_buffer_enable_ff <= ~ctrl_ff[sasr_pkg::CTRL_REF_BYPASS];
            ref_internal_enable_ff <= ctrl_ff[sasr_pkg::CTRL_REF_INTERNAL];
        end
    end

    // Lane images for one, two or three serial lines
    always_comb
    begin
        logic [sasr_pkg::WORD_BITS-1:0] w1;
        logic [sasr_pkg::WORD_BITS-1:0] w2;
        logic [sasr_pkg::WORD_BITS-1:0] w3;
        logic [sasr_pkg::WORD_BITS-1:0] w4;
        logic [sasr_pkg::WORD_BITS-1:0] w5;
        logic [sasr_pkg::WORD_BITS-1:0] w6;
        w1 = ch_word(conv_result, conv_pairs_ff, 0);
        w2 = ch_word(conv_result, conv_pairs_ff, 1);
        w3 = ch_word(conv_result, conv_pairs_ff, 2);
        w4 = ch_word(conv_result, conv_pairs_ff, 3);
        w5 = ch_word(conv_result, conv_pairs_ff, 4);
        w6 = ch_word(conv_result, conv_pairs_ff, 5);
        nxt_img_c = '0;
        nxt_img_b = '0;
        if (out_en == 3'h7)
        begin
            nxt_img_a = {w1, w2, {(4*sasr_pkg::WORD_BITS){1'b0}}};
            nxt_img_b = {w3, w4, {(4*sasr_pkg::WORD_BITS){1'b0}}};
            nxt_img_c = {w5, w6, {(4*sasr_pkg::WORD_BITS){1'b0}}};
        end
        else if (out_en[1:0] == 2'h3)
        begin
            nxt_img_a = {w1, w2, w5, {(3*sasr_pkg::WORD_BITS){1'b0}}};
            nxt_img_b = {w3, w4, w6, {(3*sasr_pkg::WORD_BITS){1'b0}}};
        end
        else
        begin
            nxt_img_a = {w1, w2, w3, w4, w5, w6};
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            img_a_ff <= '0;
            img_b_ff <= '0;
            img_c_ff <= '0;
            epoch_ff <= 1'b0;
        end
        else if (conv_end)
        begin
            img_a_ff <= nxt_img_a;
            img_b_ff <= nxt_img_b;
            img_c_ff <= nxt_img_c;
            epoch_ff <= ~epoch_ff;
        end
    end

    // Reset for the serial domain, a constant-valued clear
    always_ff @(posedge clk)
    begin
        rst_link_ff <= reset;
    end

    // New results restart the read position at zero
    assign eff_pos = (seen_ff != epoch_ff) ? '0 : pos_ff;
    assign bit_idx = sasr_pkg::POS_TOP - eff_pos;

    // read position runs on the host serial clock
    always_ff @(negedge sclk or posedge rst_link_ff)
    begin
        if (rst_link_ff)
        begin
            pos_ff <= '0;
            seen_ff <= 1'b0;
        end
        else if (!cs_n)
        begin
            pos_ff <= (eff_pos == sasr_pkg::POS_END) ? eff_pos : eff_pos + 1'b1;
            seen_ff <= epoch_ff;
        end
    end

    // lines live only in serial mode
    assign serial_on = sync2_ff[sasr_pkg::SY_SER] && !cs_n;

    // Data follows chip select without a clock edge, so it is a mux
    // MSB of the current word shown at select
    assign dout_a = (eff_pos < sasr_pkg::POS_END) && img_a_ff[bit_idx];
    assign dout_b = (eff_pos < sasr_pkg::POS_END) && img_b_ff[bit_idx];
    assign dout_c = (eff_pos < sasr_pkg::POS_END) && img_c_ff[bit_idx];
    // each line enabled by its own pin
    assign dout_a_oe = serial_on && out_en[0];
    assign dout_b_oe = serial_on && out_en[1];
    assign dout_c_oe = serial_on && out_en[2];

    assign busy = busy_ff;
    assign conv_pairs = conv_pairs_ff;
    assign pair_range = pair_range_ff;
    assign ref_buffer_enable = ref_buffer_enable_ff;
    assign ref_internal_enable = ref_internal_enable_ff;

    // Checks
    logic [sasr_pkg::CNT_W-1:0] hp_busy_len_ff;

    always_ff @(posedge clk)
    begin
        if (reset)
            hp_busy_len_ff <= '0;
        else if (ce)
            hp_busy_len_ff <= busy_ff ? hp_busy_len_ff + 1'b1 : '0;
    end

    property p_start_busy;
        @(posedge clk) disable iff (reset)
        (ce && !busy_ff && !sw_mode && start_rise != 3'h0) |=> busy_ff;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy not raised");

    property p_busy_len;
        @(posedge clk) disable iff (reset)
        $fell(busy_ff) |-> (hp_busy_len_ff == sasr_pkg::CONV_CYCLES);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

    property p_ignore;
        @(posedge clk) disable iff (reset)
        (ce && busy_ff && cnt_ff != sasr_pkg::CONV_LAST) |=> busy_ff && $stable(conv_pairs_ff);
    endproperty
    a_ignore: assert property (p_ignore) else $error("start taken while busy");

    property p_hw_range;
        @(posedge clk) disable iff (reset)
        $fell(busy_ff) |-> hw_range_ff == $past(sync2_ff[sasr_pkg::SY_RANGE]);
    endproperty
    a_hw_range: assert property (p_hw_range) else $error("range pin not caught");

    property p_sw_range;
        @(posedge clk) disable iff (reset)
        (ce && sw_mode) |=> pair_range_ff == $past(ctrl_ff[sasr_pkg::CTRL_RNG_LO +: 3]);
    endproperty
    a_sw_range: assert property (p_sw_range) else $error("software range wrong");

    property p_ref_buffer_bypass;
        @(posedge clk) disable iff (reset)
        ce |=> ref_buffer_enable_ff != $past(ctrl_ff[sasr_pkg::CTRL_REF_BYPASS]);
    endproperty
    a_ref_buffer_bypass: assert property (p_ref_buffer_bypass) else $error("buffer enable wrong");

    property p_ctrl_reset;
        @(posedge clk)
        $past(reset) |-> ctrl_ff == sasr_pkg::CTRL_RESET;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not cleared");

    property p_load;
        @(posedge clk) disable iff (reset)
        $fell(busy_ff) |-> img_a_ff[sasr_pkg::IMG_BITS-1 -: sasr_pkg::WORD_BITS] ==
            ($past(conv_pairs_ff[0]) ? ($past(conv_result[15:0]) & RES_MASK) : '0);
    endproperty
    a_load: assert property (p_load) else $error("first result not loaded");

    property p_sw_start;
        @(posedge clk) disable iff (reset)
        (ce && !busy_ff && sw_mode && !start_rise[0]) |=> !busy_ff;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("start without A");

    property p_zeros;
        @(negedge sclk) disable iff (rst_link_ff)
        (eff_pos == sasr_pkg::POS_END) |-> !dout_a && !dout_b && !dout_c;
    endproperty
    a_zeros: assert property (p_zeros) else $error("data after end");

endmodule

/* File: design/sasr_pkg.sv */
/*
 * Constants for the simultaneous-sampling converter control and serial
 * readout block: conversion timing, control word layout, frame sizes.
 * Assumes a 25 MHz system clock.
 */
package sasr_pkg;

    // Conversion time, longest figure rounds down
    localparam int CONV_TIME_NS = 3000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);

    localparam int WORD_BITS = 16;
    localparam int NUM_CH = 6;
    localparam int NUM_PAIRS = 3;
    localparam int IMG_BITS = WORD_BITS * NUM_CH;

    // Control word bit positions
    localparam int CTRL_W = 8;
    localparam int CTRL_REF_BYPASS = 0;
    localparam int CTRL_REF_INTERNAL = 1;
    localparam int CTRL_RNG_LO = 2;
    localparam int CTRL_SEL_LO = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

    // Serial read position
    localparam int POS_W = 7;
    localparam logic [POS_W-1:0] POS_END = 7'h60;
    localparam logic [POS_W-1:0] POS_TOP = 7'h5F;

    // Synchroniser vector layout
    localparam int SY_START = 0;
    localparam int SY_RANGE = 3;
    localparam int SY_SW = 4;
    localparam int SY_SER = 5;
    localparam int SY_EN = 6;
    localparam int SY_W = 9;

    typedef enum logic [0:0]
    {
        SASR_IDLE = 1'b0,
        SASR_CONV = 1'b1
    } sasr_state_e;

endpackage

/* File: dv/sasr_host_model.sv */
/*
 * Host-side reader for the three serial result lines: frames cs_n,
 * makes the serial clock and gathers the bits of each line.
 * Assumes the converter advances data on the falling serial clock edge.
 */
`timescale 1ns/1ps

module sasr_host_model (
    output logic sclk,
    output logic cs_n,
    input wire logic dout_a,
    input wire logic dout_b,
    input wire logic dout_c,
    input wire logic dout_a_oe,
    input wire logic dout_b_oe,
    input wire logic dout_c_oe
);
    logic [95:0] rx_a;
    logic [95:0] rx_b;
    logic [95:0] rx_c;
    logic [2:0] oe_seen;

    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        rx_a = '0;
        rx_b = '0;
        rx_c = '0;
        oe_seen = 3'b111;
    end

    task automatic clear();
        rx_a = '0;
        rx_b = '0;
        rx_c = '0;
        oe_seen = 3'b111;
    endtask

    task automatic frame(input int bits);
        int i;
        // Odd offset keeps the link out of phase with clk
        #7;
        cs_n = 1'b0;
        #16;
        for (i = 0; i < bits; i++)
        begin
            sclk = 1'b1;
            rx_a = {rx_a[94:0], dout_a};
            rx_b = {rx_b[94:0], dout_b};
            rx_c = {rx_c[94:0], dout_c};
            oe_seen = oe_seen & {dout_c_oe, dout_b_oe, dout_a_oe};
            #16;
            sclk = 1'b0;
            #16;
        end
        // Clock stands still low between frames
        cs_n = 1'b1;
        #16;
    endtask
endmodule

/* File: dv/tb_top.sv */
/*
 * Self-checking bench for the converter control and serial readout:
 * conversions in pin and control-word mode, reads on three, two and one line.
 * Assumes the serial reader model and the design package are compiled first.
 */
`timescale 1ns/1ps

module tb_top;
    logic clk, reset, ce, pair_a_start, pair_b_start, pair_c_start;
    logic range_pin, sw_select_mode, serial_parallel_select;
    logic out_a_enable, out_b_enable, out_c_enable, ctrl_write;
    logic [7:0] ctrl_data;
    logic [95:0] conv_result;
    logic sclk, cs_n, busy, ref_buffer_enable, ref_internal_enable;
    logic [2:0] conv_pairs, pair_range;
    logic dout_a, dout_a_oe, dout_b, dout_b_oe, dout_c, dout_c_oe;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int run_len = 0;
    int last_len = 0;

    sasr_core i_sasr_core (.clk(clk), .reset(reset), .ce(ce), .pair_a_start(pair_a_start),
        .pair_b_start(pair_b_start), .pair_c_start(pair_c_start), .range_pin(range_pin),
        .sw_select_mode(sw_select_mode), .serial_parallel_select(serial_parallel_select),
        .out_a_enable(out_a_enable), .out_b_enable(out_b_enable),
        .out_c_enable(out_c_enable), .ctrl_write(ctrl_write), .ctrl_data(ctrl_data),
        .conv_result(conv_result), .sclk(sclk), .cs_n(cs_n), .busy(busy),
        .conv_pairs(conv_pairs), .pair_range(pair_range),
        .ref_buffer_enable(ref_buffer_enable), .ref_internal_enable(ref_internal_enable),
        .dout_a(dout_a), .dout_a_oe(dout_a_oe), .dout_b(dout_b), .dout_b_oe(dout_b_oe),
        .dout_c(dout_c), .dout_c_oe(dout_c_oe));

    sasr_host_model i_sasr_host_model (.sclk(sclk), .cs_n(cs_n), .dout_a(dout_a),
        .dout_b(dout_b), .dout_c(dout_c), .dout_a_oe(dout_a_oe),
        .dout_b_oe(dout_b_oe), .dout_c_oe(dout_c_oe));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Busy run length, taken when busy drops
    always @(posedge clk)
    begin
        cycles++;
        if (busy === 1'b1)
            run_len <= run_len + 1;
        else if (run_len != 0)
        begin
            last_len <= run_len;
            run_len <= 0;
        end
        if (cycles == 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check_flag(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_stream(input logic [95:0] got, input logic [95:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] ch(input int k);
        return conv_result[16*k-1 -: 16];
    endfunction

    task automatic convert(input logic [2:0] starts, input logic retrig);
        int n;
        @(negedge clk);
        {pair_c_start, pair_b_start, pair_a_start} = starts;
        for (n = 0; n < 8 && busy !== 1'b1; n++)
            @(negedge clk);
        repeat (2) @(negedge clk);
        {pair_c_start, pair_b_start, pair_a_start} = 3'b000;
        // Fresh edges on every start while busy must change nothing
        if (retrig)
        begin
            repeat (8) @(negedge clk);
            {pair_c_start, pair_b_start, pair_a_start} = 3'b111;
            repeat (8) @(negedge clk);
            {pair_c_start, pair_b_start, pair_a_start} = 3'b000;
        end
        for (n = 0; n < 200 && busy === 1'b1; n++)
            @(negedge clk);
        repeat (3) @(negedge clk);
    endtask

    task automatic write_ctrl(input logic [7:0] data);
        @(negedge clk);
        ctrl_write = 1'b1;
        ctrl_data = data;
        @(negedge clk);
        ctrl_write = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    initial
    begin
        {reset, ce} = 2'b11;
        {pair_a_start, pair_b_start, pair_c_start, range_pin, sw_select_mode} = '0;
        {out_a_enable, out_b_enable, out_c_enable} = 3'b111;
        serial_parallel_select = 1'b1;
        ctrl_write = 1'b0;
        ctrl_data = 8'h00;
        conv_result = {16'hF60F, 16'hE50E, 16'hD40D, 16'hC30C, 16'hB20B, 16'hA10A};
        repeat (3) @(negedge clk);
        reset = 1'b0;
        check_flag({busy, ref_internal_enable, ref_buffer_enable}, 3'b001);
        check_flag(conv_pairs | pair_range, 3'b000);
        range_pin = 1'b1;
        repeat (8) @(negedge clk);
        check_flag(pair_range, 3'b000);
        convert(3'b111, 1'b1);
        check_stream(96'(last_len), 96'(sasr_pkg::CONV_CYCLES));
        check_flag(conv_pairs, 3'b111);
        check_flag(pair_range, 3'b111);
        i_sasr_host_model.clear();
        i_sasr_host_model.frame(32);
        check_stream({i_sasr_host_model.rx_a[31:0], i_sasr_host_model.rx_b[31:0],
            i_sasr_host_model.rx_c[31:0]}, {ch(1), ch(2), ch(3), ch(4), ch(5), ch(6)});
        check_flag(i_sasr_host_model.oe_seen, 3'b111);
        check_flag({dout_c_oe, dout_b_oe, dout_a_oe}, 3'b000);
        i_sasr_host_model.clear();
        i_sasr_host_model.frame(16);
        check_stream({i_sasr_host_model.rx_a[15:0], i_sasr_host_model.rx_b[15:0],
            i_sasr_host_model.rx_c[15:0], 48'h0}, 96'h0);
        conv_result = ~conv_result;
        out_c_enable = 1'b0;
        range_pin = 1'b0;
        convert(3'b011, 1'b0);
        check_flag(conv_pairs, 3'b011);
        check_flag(pair_range, 3'b000);
        i_sasr_host_model.clear();
        i_sasr_host_model.frame(48);
        check_stream({i_sasr_host_model.rx_a[47:0], i_sasr_host_model.rx_b[47:0]},
            {ch(1), ch(2), 16'h0000, ch(3), ch(4), 16'h0000});
        check_flag(i_sasr_host_model.oe_seen, 3'b011);
        sw_select_mode = 1'b1;
        out_b_enable = 1'b0;
        write_ctrl(8'h97);
        check_flag({1'b0, ref_internal_enable, ref_buffer_enable}, 3'b010);
        check_flag(pair_range, 3'b101);
        convert(3'b010, 1'b0);
        check_flag(conv_pairs, 3'b011);
        convert(3'b001, 1'b0);
        check_flag(conv_pairs, 3'b100);
        check_flag(pair_range, 3'b101);
        i_sasr_host_model.clear();
        repeat (6) i_sasr_host_model.frame(16);
        check_stream(i_sasr_host_model.rx_a, {64'h0, ch(5), ch(6)});
        check_flag(i_sasr_host_model.oe_seen, 3'b001);
        write_ctrl(8'h00);
        check_flag({1'b0, ref_internal_enable, ref_buffer_enable}, 3'b001);
        // Second reset in mid-run after a control write
        write_ctrl(8'hFF);
        @(negedge clk);
        reset = 1'b1;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        check_flag({busy, ref_internal_enable, ref_buffer_enable}, 3'b001);
        check_flag(conv_pairs, 3'b000);
        end_of_test();
    end
endmodule
